/* File: common/oad_regs.svh */
`ifndef OAD_REGS_SVH
`define OAD_REGS_SVH

// ****************************************
// internal data memory boundaries
// ****************************************
`define OAD_BANK_TOP      8'h20
`define OAD_BANK_SHIFT    3
`define OAD_SREG_BASE     8'h80
`define OAD_BIT_BYTE_BASE 8'h20
`define OAD_BIT_SREG_BASE 8'h80

// ****************************************
// extension ram and external space
// ****************************************
`define OAD_AUX_SIZE      16'h0300
`define OAD_AUX_PAGE_BAD  2'h3
`define OAD_ZERO_BYTE     8'h00

// ****************************************
// reset values
// ****************************************
`define OAD_RST_ADDR      16'h0000
`define OAD_RST_POS       3'h0

`endif

/* File: common/oad_pkg.sv */
package oad_pkg;

	// ****************************************
	// operand addressing methods
	// ****************************************
	typedef enum logic [4:0] {
		OAD_MODE_REG   = 5'h01,
		OAD_MODE_DIR   = 5'h02,
		OAD_MODE_IND   = 5'h04,
		OAD_MODE_IMM   = 5'h08,
		OAD_MODE_BASE  = 5'h10
	} oad_mode_t;

	// ****************************************
	// memory spaces
	// ****************************************
	typedef enum logic [7:0] {
		OAD_SP_NONE    = 8'h00,
		OAD_SP_BANK    = 8'h01,
		OAD_SP_IRAM_LO = 8'h02,
		OAD_SP_IRAM_HI = 8'h04,
		OAD_SP_SREG    = 8'h08,
		OAD_SP_AUX     = 8'h10,
		OAD_SP_XDATA   = 8'h20,
		OAD_SP_CODE    = 8'h40,
		OAD_SP_IMM     = 8'h80
	} oad_space_t;

	// ****************************************
	// sequencer request and memory access
	// ****************************************
	typedef struct packed {
		oad_mode_t   mode;
		logic [7:0]  operand;
		logic [15:0] ptr;
		logic        wide_ptr;
		logic        ext_move;
		logic        bit_op;
		logic        dest;
		logic        move;
		logic [15:0] base;
		logic [7:0]  index;
	} oad_req_t;

	typedef struct packed {
		oad_space_t  space;
		logic [15:0] addr;
		logic [2:0]  bit_pos;
		logic        bit_op;
		logic        rd;
		logic        wr;
	} oad_acc_t;

endpackage

/* File: core/oad_bit_map.sv */
`timescale 1ns/1ps
`include "oad_regs.svh"

module oad_bit_map
	import oad_pkg::*;
(
	// bit address in
	input  wire logic [7:0] bit_addr,
	// byte location out
	output oad_space_t      space,
	output logic [7:0]      byte_addr,
	output logic [2:0]      bit_pos
);

	always_comb begin
		bit_pos = bit_addr[2:0];
		if (bit_addr < `OAD_BIT_SREG_BASE) begin
			space     = OAD_SP_IRAM_LO;
			byte_addr = `OAD_BIT_BYTE_BASE + {3'h0, bit_addr[7:3]};
		end else begin
			space     = OAD_SP_SREG;
			byte_addr = {bit_addr[7:3], 3'h0};
		end
	end

endmodule

/* File: core/oad_decoder.sv */
`timescale 1ns/1ps
`include "oad_regs.svh"

// How it works
// - five addressing methods, others flagged
// - destination only register, direct, indirect
// - non-move destination read before write
// - bank registers reachable three ways
// - ram 0-127 direct and indirect
// - ram 128-255 indirect only
// - extension ram only by external move
// - special register space only direct 128-255
// - external data only register-indirect
// - table address is base plus index
// - four banks of eight, one active
// - bytes 32-47 hold 128 bits
module oad_decoder
	import oad_pkg::*;
(
	// clock and reset
	input  wire logic       CLK,
	input  wire logic       RST,
	// sequencer request
	input  wire logic       REQ_VALID,
	input  oad_req_t        REQ,
	output logic            REQ_READY,
	// core state
	input  wire logic [1:0] BANK_SEL,
	input  wire logic [1:0] AUX_PAGE,
	input  wire logic       AUX_DISABLE,
	// memory access
	output logic            ACC_VALID,
	output oad_acc_t        ACC,
	output logic            ERR
);

	// ****************************************
	// decode helpers
	// ****************************************

	// internal byte address to its ram region
	function automatic oad_space_t iram_space(input logic [7:0] a);
		if (a < `OAD_BANK_TOP)
			iram_space = OAD_SP_BANK;
		else if (a < `OAD_SREG_BASE)
			iram_space = OAD_SP_IRAM_LO;
		else
			iram_space = OAD_SP_IRAM_HI;
	endfunction

	// ****************************************
	// sequencing states
	// ****************************************
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h1,
		ST_READ  = 3'h2,
		ST_WRITE = 3'h4
	} oad_state_t;

	oad_state_t  state;
	oad_state_t  next_state;
	oad_space_t  dec_space;
	logic [15:0] dec_addr;
	logic [2:0]  dec_pos;
	logic        dec_err;
	oad_space_t  bit_space;
	logic [7:0]  bit_byte;
	logic [2:0]  bit_pos;
	logic [15:0] aux_addr;
	logic        take;
	oad_space_t  held_space;
	logic [15:0] held_addr;
	logic [2:0]  held_pos;
	logic        held_bit;

	assign take = REQ_VALID && (state == ST_IDLE);

	oad_bit_map u_bit_map (
		.bit_addr  (REQ.operand),
		.space     (bit_space),
		.byte_addr (bit_byte),
		.bit_pos   (bit_pos)
	);

	// page selects one 256-byte slice of the extension ram
	assign aux_addr = {6'h00, AUX_PAGE, REQ.ptr[7:0]};

	// ****************************************
	// location decode
	// ****************************************
	always_comb begin
		dec_space = OAD_SP_NONE;
		dec_addr  = `OAD_RST_ADDR;
		dec_pos   = `OAD_RST_POS;
		dec_err   = 1'b0;
		case (REQ.mode)
			OAD_MODE_REG: begin
				dec_space = OAD_SP_BANK;
				dec_addr  = {8'h00, 3'h0, BANK_SEL, REQ.operand[2:0]};
			end
			OAD_MODE_DIR: begin
				if (REQ.bit_op) begin
					dec_space = bit_space;
					dec_addr  = {8'h00, bit_byte};
					dec_pos   = bit_pos;
				end else if (REQ.operand >= `OAD_SREG_BASE) begin
					// upper half direct means special registers
					dec_space = OAD_SP_SREG;
					dec_addr  = {8'h00, REQ.operand};
				end else begin
					dec_space = iram_space(REQ.operand);
					dec_addr  = {8'h00, REQ.operand};
				end
			end
			OAD_MODE_IND: begin
				if (!REQ.ext_move) begin
					dec_space = iram_space(REQ.ptr[7:0]);
					dec_addr  = {8'h00, REQ.ptr[7:0]};
				end else if (REQ.wide_ptr) begin
					if (AUX_DISABLE || REQ.ptr >= `OAD_AUX_SIZE)
						dec_space = OAD_SP_XDATA;
					else
						dec_space = OAD_SP_AUX;
					dec_addr = REQ.ptr;
				end else if (AUX_DISABLE) begin
					dec_space = OAD_SP_XDATA;
					dec_addr  = {`OAD_ZERO_BYTE, REQ.ptr[7:0]};
				end else if (AUX_PAGE == `OAD_AUX_PAGE_BAD) begin
					// reserved page: no memory answers
					dec_err = 1'b1;
				end else begin
					dec_space = OAD_SP_AUX;
					dec_addr  = aux_addr;
				end
			end
			OAD_MODE_IMM: begin
				dec_space = OAD_SP_IMM;
				dec_addr  = {8'h00, REQ.operand};
				dec_err   = REQ.dest;
			end
			OAD_MODE_BASE: begin
				dec_space = OAD_SP_CODE;
				dec_addr  = REQ.base + {8'h00, REQ.index};
				dec_err   = REQ.dest;
			end
			default: begin
				dec_err = 1'b1;
			end
		endcase
	end

	// ****************************************
	// read-modify-write sequencing
	// ****************************************
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (take && !dec_err) begin
					if (REQ.dest && !REQ.move)
						next_state = ST_READ;
					else if (REQ.dest)
						next_state = ST_WRITE;
					else
						next_state = ST_READ;
				end
			end
			ST_READ: begin
				if (ACC.wr)
					next_state = ST_WRITE;
				else
					next_state = ST_IDLE;
			end
			ST_WRITE: next_state = ST_IDLE;
			default:  next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	// ****************************************
	// held location across both phases
	// ****************************************
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			held_space <= OAD_SP_NONE;
			held_addr  <= `OAD_RST_ADDR;
			held_pos   <= `OAD_RST_POS;
			held_bit   <= 1'b0;
		end else if (take && !dec_err) begin
			held_space <= dec_space;
			held_addr  <= dec_addr;
			held_pos   <= dec_pos;
			held_bit   <= REQ.bit_op;
		end
	end

	// ****************************************
	// access outputs
	// ****************************************
	// wr stays set during a read phase to mark the pending writeback
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ACC_VALID <= 1'b0;
			ACC       <= '0;
		end else begin
			ACC_VALID <= (next_state == ST_READ) ||
			             (next_state == ST_WRITE);
			if (take && !dec_err) begin
				ACC.space   <= dec_space;
				ACC.addr    <= dec_addr;
				ACC.bit_pos <= dec_pos;
				ACC.bit_op  <= REQ.bit_op;
				ACC.rd      <= !(REQ.dest && REQ.move);
				ACC.wr      <= REQ.dest;
			end else if (next_state == ST_WRITE) begin
				ACC.space   <= held_space;
				ACC.addr    <= held_addr;
				ACC.bit_pos <= held_pos;
				ACC.bit_op  <= held_bit;
				ACC.rd      <= 1'b0;
				ACC.wr      <= 1'b1;
			end else if (next_state == ST_IDLE) begin
				ACC.rd <= 1'b0;
				ACC.wr <= 1'b0;
			end
		end
	end

	// ****************************************
	// handshake and error
	// ****************************************
	always_ff @(posedge CLK or posedge RST) begin
		if (RST)
			REQ_READY <= 1'b1;
		else
			REQ_READY <= (next_state == ST_IDLE);
	end

	// refused requests flag for one cycle, no access issued
	always_ff @(posedge CLK or posedge RST) begin
		if (RST)
			ERR <= 1'b0;
		else
			ERR <= take && dec_err;
	end

endmodule

/* File: sim/oad_decoder_chk.sv */
`timescale 1ns/1ps

module oad_decoder_chk
	import oad_pkg::*;
(
	// clock and request
	input wire logic       CLK,
	input wire logic       RST,
	input wire logic       REQ_VALID,
	input oad_req_t        REQ,
	input wire logic       REQ_READY,
	input wire logic [1:0] BANK_SEL,
	input wire logic [1:0] AUX_PAGE,
	input wire logic       AUX_DISABLE,
	// access
	input wire logic       ACC_VALID,
	input oad_acc_t        ACC,
	input wire logic       ERR
);
	// ********
	// properties
	// ********
	default clocking @(posedge CLK);
	endclocking
	default disable iff (RST);

	wire logic take = REQ_VALID && REQ_READY;

	a_take_answer: assert property (take |=> ACC_VALID || ERR)
		else $error("request left unanswered");
	a_dest_refused: assert property (take && REQ.dest &&
		REQ.mode inside {OAD_MODE_IMM, OAD_MODE_BASE} |=> ERR && !ACC_VALID)
		else $error("bad destination form accepted");
	a_rmw_write: assert property (ACC_VALID && ACC.rd && ACC.wr |->
		!REQ_READY ##1 ACC_VALID && !ACC.rd && ACC.wr && $stable(ACC.addr))
		else $error("writeback phase missing");
	a_bank_range: assert property (ACC_VALID &&
		ACC.space == OAD_SP_BANK |-> ACC.addr < 16'h0020)
		else $error("bank address out of range");
	a_ram_low: assert property (ACC_VALID &&
		ACC.space == OAD_SP_IRAM_LO |-> ACC.addr < 16'h0080)
		else $error("low ram address out of range");
	a_ram_high: assert property (ACC_VALID &&
		ACC.space == OAD_SP_IRAM_HI |-> ACC.addr[15:7] == 9'h001)
		else $error("high ram address out of range");
	a_sreg_range: assert property (ACC_VALID &&
		ACC.space == OAD_SP_SREG |-> ACC.addr[15:7] == 9'h001)
		else $error("register space address out of range");
	a_aux_range: assert property (ACC_VALID &&
		ACC.space == OAD_SP_AUX |-> ACC.addr < 16'h0300)
		else $error("extension ram address out of range");
	a_bit_byte: assert property (take && REQ.bit_op &&
		REQ.mode == OAD_MODE_DIR && REQ.operand < 8'h80 |=>
		ACC.addr[15:4] == 12'h002 && ACC.bit_pos == $past(REQ.operand[2:0]))
		else $error("bit byte or position wrong");

	c_rmw: cover property (ACC_VALID && ACC.rd && ACC.wr);
	c_err: cover property (ERR);
	c_aux: cover property (ACC_VALID && ACC.space == OAD_SP_AUX);
endmodule

bind oad_decoder oad_decoder_chk oad_decoder_chk_i (.CLK(CLK), .RST(RST),
	.REQ_VALID(REQ_VALID), .REQ(REQ), .REQ_READY(REQ_READY),
	.BANK_SEL(BANK_SEL), .AUX_PAGE(AUX_PAGE), .AUX_DISABLE(AUX_DISABLE),
	.ACC_VALID(ACC_VALID), .ACC(ACC), .ERR(ERR));

/* File: sim/tb_top.sv */
`timescale 1ns/1ps

module tb_top
	import oad_pkg::*;
;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic       req_valid = 1'b0;
	oad_req_t   req = '0;
	logic       req_ready;
	logic [1:0] bank_sel = 2'h0;
	logic [1:0] aux_page = 2'h0;
	logic       aux_disable = 1'b0;
	logic       acc_valid;
	oad_acc_t   acc;
	logic       err;
	logic [7:0] idx_v = 8'h00;
	int         num_errors = 0;
	int         checks_done = 0;
	int         cycles = 0;

	always #2.5 clk = ~clk;

	oad_decoder oad_decoder_i (.CLK(clk), .RST(rst), .REQ_VALID(req_valid),
		.REQ(req), .REQ_READY(req_ready), .BANK_SEL(bank_sel),
		.AUX_PAGE(aux_page), .AUX_DISABLE(aux_disable),
		.ACC_VALID(acc_valid), .ACC(acc), .ERR(err));

	// ********
	// shared tasks
	// ********
	task automatic chk(input logic ok);
		checks_done++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("Error at %0t ns: access mismatch", $time);
		end
	endtask

	// flags: wide, ext_move, bit_op, dest, move; space none means refused
	task automatic go(input oad_mode_t m, input logic [15:0] v,
		input logic [4:0] f, input oad_space_t sp, input logic [15:0] ad);
		req = '{m, v[7:0], v, f[4], f[3], f[2], f[1], f[0], v, idx_v};
		req_valid = 1'b1;
		@(negedge clk);
		req_valid = 1'b0;
		if (sp == OAD_SP_NONE) begin
			chk(err === 1'b1 && acc_valid === 1'b0);
			chk(req_ready === 1'b1);
		end else begin
			chk(acc_valid === 1'b1 && acc.space === sp);
			chk(acc.addr === ad);
			chk(acc.rd === !(f[1] && f[0]) && acc.wr === f[1]);
			chk(acc.bit_op === f[2] && err === 1'b0);
			chk(req_ready === 1'b0);
			if (f[2])
				chk(acc.bit_pos === v[2:0]);
			if (f[1] && !f[0]) begin
				@(negedge clk);
				chk(acc_valid === 1'b1 && {acc.rd, acc.wr} === 2'h1);
				chk(acc.addr === ad && req_ready === 1'b0);
			end
		end
		@(negedge clk);
		// access pulses end after their last phase, error pulses after one cycle
		chk(acc_valid === 1'b0 && err === 1'b0);
		chk(req_ready === 1'b1);
	endtask

	task automatic final_report();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ********
	// scenarios
	// ********
	task automatic t_space();
		for (int b = 0; b < 4; b++) begin
			bank_sel = 2'(b);
			go(OAD_MODE_REG, 16'h0005, 5'h00, OAD_SP_BANK, 16'(b*8+5));
		end
		go(OAD_MODE_DIR, 16'h001f, 5'h00, OAD_SP_BANK, 16'h001f);
		go(OAD_MODE_IND, 16'h000d, 5'h00, OAD_SP_BANK, 16'h000d);
		go(OAD_MODE_DIR, 16'h007f, 5'h00, OAD_SP_IRAM_LO, 16'h007f);
		go(OAD_MODE_IND, 16'h0020, 5'h00, OAD_SP_IRAM_LO, 16'h0020);
		go(OAD_MODE_IND, 16'h0080, 5'h00, OAD_SP_IRAM_HI, 16'h0080);
		go(OAD_MODE_DIR, 16'h0080, 5'h00, OAD_SP_SREG, 16'h0080);
		go(OAD_MODE_DIR, 16'h00ff, 5'h00, OAD_SP_SREG, 16'h00ff);
		$display("space test done");
	endtask

	task automatic t_dest();
		go(OAD_MODE_DIR, 16'h0090, 5'h02, OAD_SP_SREG, 16'h0090);
		go(OAD_MODE_REG, 16'h0002, 5'h02, OAD_SP_BANK, 16'h001a);
		go(OAD_MODE_IND, 16'h00c4, 5'h03, OAD_SP_IRAM_HI, 16'h00c4);
		go(OAD_MODE_IMM, 16'h005a, 5'h00, OAD_SP_IMM, 16'h005a);
		go(OAD_MODE_IMM, 16'h005a, 5'h02, OAD_SP_NONE, 16'h0000);
		go(OAD_MODE_BASE, 16'h1000, 5'h03, OAD_SP_NONE, 16'h0000);
		go(oad_mode_t'(5'h03), 16'h0010, 5'h00, OAD_SP_NONE, 16'h0000);
		$display("destination test done");
	endtask

	task automatic t_aux();
		aux_page = 2'h2;
		go(OAD_MODE_IND, 16'h02ff, 5'h18, OAD_SP_AUX, 16'h02ff);
		go(OAD_MODE_IND, 16'h0300, 5'h18, OAD_SP_XDATA, 16'h0300);
		go(OAD_MODE_IND, 16'h0045, 5'h08, OAD_SP_AUX, 16'h0245);
		aux_page = 2'h3;
		go(OAD_MODE_IND, 16'h0045, 5'h08, OAD_SP_NONE, 16'h0000);
		aux_disable = 1'b1;
		// wide pointer inside extension range goes external when disabled
		go(OAD_MODE_IND, 16'h0100, 5'h18, OAD_SP_XDATA, 16'h0100);
		go(OAD_MODE_IND, 16'h0045, 5'h08, OAD_SP_XDATA, 16'h0045);
		go(OAD_MODE_IND, 16'h8000, 5'h1a, OAD_SP_XDATA, 16'h8000);
		$display("extension test done");
	endtask

	task automatic t_table();
		idx_v = 8'h20;
		go(OAD_MODE_BASE, 16'hfff0, 5'h00, OAD_SP_CODE, 16'h0010);
		idx_v = 8'h05;
		go(OAD_MODE_BASE, 16'h1234, 5'h00, OAD_SP_CODE, 16'h1239);
		go(OAD_MODE_DIR, 16'h007f, 5'h04, OAD_SP_IRAM_LO, 16'h002f);
		go(OAD_MODE_DIR, 16'h0000, 5'h04, OAD_SP_IRAM_LO, 16'h0020);
		go(OAD_MODE_DIR, 16'h0083, 5'h04, OAD_SP_SREG, 16'h0080);
		go(OAD_MODE_DIR, 16'h00ff, 5'h06, OAD_SP_SREG, 16'h00f8);
		$display("table and bit test done");
	endtask

	// ********
	// run
	// ********
	// ceiling well above the roughly 80 cycles the tests need
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			num_errors++;
			final_report();
		end
	end

	initial begin
		repeat (16) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		t_space();
		t_dest();
		t_aux();
		t_table();
		final_report();
	end
endmodule
